// [inc/status_pkg.sv]
// Constants, types and helpers shared by the status register block
package status_pkg;

  // ****************************************************************
  // Register indices; the byte address is the index times four
  // ****************************************************************
  localparam logic [7:0] IDX_STATUS_B0 = 8'h03;
  localparam logic [7:0] IDX_STATUS_B1 = 8'h83;
  localparam logic [7:0] IDX_LAST_RESULT = 8'h10;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int BIT_C = 0;
  localparam int BIT_DC = 1;
  localparam int BIT_Z = 2;
  localparam int BIT_PD = 3;
  localparam int BIT_TO = 4;
  localparam int BIT_RP0 = 5;
  localparam int BIT_RP1 = 6;
  localparam int BIT_IRP = 7;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] DATA_WR_MASK = 8'hE7;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam int BANK_ADDR_W = 7;
  localparam logic [1:0] BANK0_CODE = 2'h0;
  localparam logic [1:0] BANK1_CODE = 2'h1;

  // ****************************************************************
  // Bus encodings
  // ****************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ****************************************************************
  // Operations and the flag unit's answer
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_CLR, OP_INC, OP_DEC,
    OP_RLF, OP_RRF, OP_MOV, OP_BCF, OP_BSF, OP_SWAP, OP_NOP
  } op_t;

  typedef struct packed {
    logic [7:0] res;
    logic z;
    logic dc;
    logic c;
    logic aff_z;
    logic aff_dc;
    logic aff_c;
    logic wr;
  } alu_out_t;

  // Both banked copies of the status location
  function automatic logic is_status_loc(input logic [7:0] a);
    is_status_loc = (a == IDX_STATUS_B0) || (a == IDX_STATUS_B1);
  endfunction

endpackage

// [hdl/flag_alu.sv]
// Result and flag computation for one executed operation
`timescale 1ns/1ps
`default_nettype none
module flag_alu (
  input wire status_pkg::op_t op,      // Operation
  input wire logic [7:0] w,            // Accumulator operand
  input wire logic [7:0] f,            // File operand
  input wire logic cin,                // Current carry
  input wire logic [2:0] bit_sel,      // Bit index for bit ops
  output status_pkg::alu_out_t out     // Result and flags
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] addend;
  logic sub;

  always_comb begin
    out = '0;
    sub = (op == status_pkg::OP_SUB);
    // (R12) Subtract as add of complement
    addend = sub ? ~w : w;
    sum = {1'h0, f} + {1'h0, addend} + {8'h00, sub};
    nib = {1'h0, f[3:0]} + {1'h0, addend[3:0]} + {4'h0, sub};
    out.wr = 1'h1;
    case (op)
      status_pkg::OP_ADD, status_pkg::OP_SUB: begin
        out.res = sum[7:0];
        // (R11) Carries double as borrows
        out.c = sum[8];
        // (R16) Low nibble carry out
        out.dc = nib[4];
        out.aff_c = 1'h1;
        out.aff_dc = 1'h1;
        out.aff_z = 1'h1;
      end
      status_pkg::OP_AND: begin
        out.res = f & w;
        out.aff_z = 1'h1;
      end
      status_pkg::OP_IOR: begin
        out.res = f | w;
        out.aff_z = 1'h1;
      end
      status_pkg::OP_XOR: begin
        out.res = f ^ w;
        out.aff_z = 1'h1;
      end
      status_pkg::OP_CLR: begin
        out.res = 8'h00;
        out.aff_z = 1'h1;
      end
      status_pkg::OP_INC: begin
        out.res = f + 8'h01;
        out.aff_z = 1'h1;
      end
      status_pkg::OP_DEC: begin
        out.res = f - 8'h01;
        out.aff_z = 1'h1;
      end
      // (R13) Rotate loads carry from end bit
      status_pkg::OP_RLF: begin
        out.res = {f[6:0], cin};
        out.c = f[7];
        out.aff_c = 1'h1;
      end
      status_pkg::OP_RRF: begin
        out.res = {cin, f[7:1]};
        out.c = f[0];
        out.aff_c = 1'h1;
      end
      status_pkg::OP_MOV: out.res = w;
      status_pkg::OP_BCF: begin
        out.res = f;
        out.res[bit_sel] = 1'h0;
      end
      status_pkg::OP_BSF: begin
        out.res = f;
        out.res[bit_sel] = 1'h1;
      end
      status_pkg::OP_SWAP: out.res = {f[3:0], f[7:4]};
      default: begin
        out.res = f;
        out.wr = 1'h0;
      end
    endcase
    // (R10) Zero flag from the result
    out.z = (out.res == 8'h00);
  end
endmodule
`default_nettype wire

// [hdl/bank_decode.sv]
// Direct address to banked data address decode
`timescale 1ns/1ps
`default_nettype none
module bank_decode #(
  parameter int AW = status_pkg::BANK_ADDR_W  // Address bits per bank
) (
  input wire logic [1:0] bank_field,    // Direct bank select field
  input wire logic [AW-1:0] dir_addr,   // Address inside the bank
  output logic [AW:0] full_addr,        // Banked data address
  output logic status_hit               // Targets the status location
);
  always_comb begin
    // (R6) Field 01 picks upper bank, 00 lower
    // (R7) Each bank spans 2**AW bytes
    // Reserved upper bit is not decoded
    full_addr = {bank_field[0], dir_addr};
    status_hit = status_pkg::is_status_loc(full_addr);
  end
endmodule
`default_nettype wire

// [hdl/alu_status_register.sv]
// Core status register with flag, reset-cause and bank select bits
//
// Functional notes
// (R1) Status decoded at 03h and 83h, one physical register.
// (R2) Status accepted as destination of any instruction.
// (R3) Flag-affecting instruction to status drops data write to flags.
// (R4) Timeout and power-down bits ignore every write.
// (R5) Clear to status zeroes upper bits, keeps reset bits, sets zero.
// (R6) Bank field 01 selects 80h-FFh, 00 selects 00h-7Fh.
// (R7) Each direct bank spans 128 bytes.
// (R8) Software keeps bit 6 clear; it is reserved.
// (R9) Software writes zero to bits 7:6, no general storage.
// (R10) Zero flag set on zero result, cleared otherwise.
// (R11) Carry and digit carry act as active-low borrows in subtract.
// (R12) Subtract adds two's complement; carry from that addition.
// (R13) Rotate loads carry from high or low operand bit.
// (R14) Reset clears bank bit, sets timeout and power-down bits.
// (R15) Timeout/power-down bits follow power-up, clear, sleep, expiry.
// (R16) Digit carry set on carry out of low nibble.
`timescale 1ns/1ps
`default_nettype none
module alu_status_register (
  input wire logic CLK,                 // Core clock
  input wire logic NRST,                // Async reset, active low
  input wire logic HSEL,                // Slave select
  input wire logic [31:0] HADDR,        // Byte address
  input wire logic [1:0] HTRANS,        // Transfer type
  input wire logic HWRITE,              // Write transfer
  input wire logic [2:0] HSIZE,         // Transfer size
  input wire logic [31:0] HWDATA,       // Write data
  input wire logic HREADY,              // Bus ready
  output logic [31:0] HRDATA,           // Read data
  output logic HREADYOUT,               // Slave ready
  output logic HRESP,                   // Response
  input wire logic EXEC,                // Instruction execute strobe
  input wire status_pkg::op_t OP,       // Operation
  input wire logic [6:0] FILE_ADDR,     // Direct file address
  input wire logic [2:0] BIT_SEL,       // Bit index
  input wire logic DEST_FILE,           // Result to file, else to W
  input wire logic [7:0] W_IN,          // Accumulator value
  input wire logic [7:0] FILE_IN,       // File operand from memory
  input wire logic WDT_CLEAR,           // Watchdog clear executed
  input wire logic SLEEP_EXEC,          // Sleep executed
  input wire logic WDT_TIMEOUT,         // Watchdog expired
  output logic [7:0] RESULT,            // Operation result
  output logic [7:0] RESULT_ADDR,       // Banked file address
  output logic RESULT_WE,               // Write result to file
  output logic RESULT_W_WE,             // Write result to W
  output logic [7:0] STATUS_OUT         // Status register value
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic wr_ph_r, wr_ph_nxt;
  logic wr_st_r, wr_st_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] result_r, result_nxt;
  logic [7:0] raddr_r, raddr_nxt;
  logic rwe_r, rwe_nxt;
  logic wwe_r, wwe_nxt;
  logic accept;
  logic [7:0] idx;
  logic idx_ok;
  logic ahb_st_wr;

  always_comb begin
    accept = HSEL && HREADY && (HTRANS == status_pkg::HTRANS_NONSEQ);
    idx = HADDR[status_pkg::IDX_LSB +: status_pkg::IDX_W];
    idx_ok = (HADDR[31:status_pkg::IDX_LSB + status_pkg::IDX_W] == '0)
      && (HADDR[status_pkg::IDX_LSB-1:0] == '0);
    wr_ph_nxt = accept && HWRITE;
    // (R1) Both mirrored indices reach one register
    wr_st_nxt = accept && HWRITE && idx_ok
      && status_pkg::is_status_loc(idx);
    rdata_nxt = rdata_r;
    if (accept && !HWRITE) begin
      rdata_nxt = '0;
      if (idx_ok && status_pkg::is_status_loc(idx)) begin
        rdata_nxt[7:0] = status_r;
      end else if (idx_ok && idx == status_pkg::IDX_LAST_RESULT) begin
        rdata_nxt[7:0] = result_r;
      end
    end
    ahb_st_wr = wr_ph_r && wr_st_r;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_ph_r <= 1'h0;
      wr_st_r <= 1'h0;
      rdata_r <= '0;
    end else begin
      wr_ph_r <= wr_ph_nxt;
      wr_st_r <= wr_st_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Never stalls: a core update in the same cycle simply overrides
  assign HRDATA = rdata_r;
  assign HREADYOUT = wr_ph_r | 1'h1;
  assign HRESP = status_pkg::HRESP_OKAY & wr_ph_r;

  // ****************************************************************
  // Operand routing and decode
  // ****************************************************************
  logic [7:0] full_addr;
  logic st_hit;
  logic [7:0] f_op;
  status_pkg::alu_out_t alu;

  bank_decode #(.AW(status_pkg::BANK_ADDR_W)) u_dec (
    .bank_field(status_r[status_pkg::BIT_RP1:status_pkg::BIT_RP0]),
    .dir_addr(FILE_ADDR),
    .full_addr(full_addr),
    .status_hit(st_hit)
  );

  assign f_op = st_hit ? status_r : FILE_IN;

  flag_alu u_alu (
    .op(OP),
    .w(W_IN),
    .f(f_op),
    .cin(status_r[status_pkg::BIT_C]),
    .bit_sel(BIT_SEL),
    .out(alu)
  );

  // ****************************************************************
  // Status register update
  // ****************************************************************
  logic any_aff;
  logic core_st_wr;

  always_comb begin
    any_aff = alu.aff_z || alu.aff_dc || alu.aff_c;
    // (R2) Status is an ordinary destination
    core_st_wr = EXEC && DEST_FILE && st_hit && alu.wr;
    status_nxt = status_r;
    // (R4) Software write keeps reset-cause bits
    if (ahb_st_wr) begin
      status_nxt = (status_r & ~status_pkg::DATA_WR_MASK)
        | (HWDATA[7:0] & status_pkg::DATA_WR_MASK);
    end
    if (core_st_wr) begin
      status_nxt[7:5] = alu.res[7:5];
      // (R3) Flag write suppressed for flag-affecting ops
      if (!any_aff) begin
        status_nxt[2:0] = alu.res[2:0];
      end
    end
    // (R5) Clear sets zero from the flag logic
    if (EXEC && alu.aff_z) begin
      status_nxt[status_pkg::BIT_Z] = alu.z;
    end
    if (EXEC && alu.aff_dc) begin
      status_nxt[status_pkg::BIT_DC] = alu.dc;
    end
    if (EXEC && alu.aff_c) begin
      status_nxt[status_pkg::BIT_C] = alu.c;
    end
    // (R15) Reset-cause events, expiry applied last
    if (WDT_CLEAR) begin
      status_nxt[status_pkg::BIT_TO] = 1'h1;
      status_nxt[status_pkg::BIT_PD] = 1'h1;
    end
    if (SLEEP_EXEC) begin
      status_nxt[status_pkg::BIT_TO] = 1'h1;
      status_nxt[status_pkg::BIT_PD] = 1'h0;
    end
    if (WDT_TIMEOUT) begin
      status_nxt[status_pkg::BIT_TO] = 1'h0;
    end
  end

  // (R14) Power-on value; flags start cleared
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      status_r <= status_pkg::STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign STATUS_OUT = status_r;

  // ****************************************************************
  // Result path to the data memory and accumulator
  // ****************************************************************
  always_comb begin
    result_nxt = result_r;
    raddr_nxt = raddr_r;
    rwe_nxt = 1'h0;
    wwe_nxt = 1'h0;
    if (EXEC) begin
      result_nxt = alu.res;
      // (R6) Banked address from the bank field
      raddr_nxt = full_addr;
      rwe_nxt = DEST_FILE && alu.wr && !st_hit;
      wwe_nxt = !DEST_FILE && alu.wr;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      result_r <= status_pkg::RESULT_RST;
      raddr_r <= '0;
      rwe_r <= 1'h0;
      wwe_r <= 1'h0;
    end else begin
      result_r <= result_nxt;
      raddr_r <= raddr_nxt;
      rwe_r <= rwe_nxt;
      wwe_r <= wwe_nxt;
    end
  end

  assign RESULT = result_r;
  assign RESULT_ADDR = raddr_r;
  assign RESULT_WE = rwe_r;
  assign RESULT_W_WE = wwe_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  logic no_evt;
  assign no_evt = !WDT_CLEAR && !SLEEP_EXEC && !WDT_TIMEOUT;

  sequence st_read_s;
    accept && !HWRITE && idx_ok && status_pkg::is_status_loc(idx);
  endsequence

  sequence st_exec_s(status_pkg::op_t o);
    EXEC && DEST_FILE && st_hit && OP == o && !ahb_st_wr && no_evt;
  endsequence

  mirror_read_a: assert property ( // (R1)
    st_read_s |=> HRDATA == {24'h000000, $past(status_r)})
    else $error("status read mismatch");

  reset_bits_a: assert property ( // (R4)
    (ahb_st_wr && !EXEC && no_evt) |=>
      status_r[4:3] == $past(status_r[4:3]))
    else $error("reset-cause bits written");

  flag_guard_a: assert property ( // (R3)
    st_exec_s(status_pkg::OP_ADD) |=>
      status_r[2:0] == {$past(alu.z), $past(alu.dc), $past(alu.c)})
    else $error("flags took data write");

  clear_status_a: assert property ( // (R5)
    st_exec_s(status_pkg::OP_CLR) |=> status_r[7:5] == 3'h0
      && status_r[status_pkg::BIT_Z]
      && status_r[4:3] == $past(status_r[4:3]))
    else $error("clear to status wrong");

  bit_dest_a: assert property ( // (R2)
    st_exec_s(status_pkg::OP_BSF) ##0 BIT_SEL == 3'h5 |=>
      status_r[status_pkg::BIT_RP0])
    else $error("bit set on status lost");

  bank_addr_a: assert property ( // (R6)
    EXEC && !st_hit |=> RESULT_ADDR[7] ==
      $past(status_r[status_pkg::BIT_RP0]) &&
      RESULT_ADDR[6:0] == $past(FILE_ADDR))
    else $error("bank address wrong");

  zero_flag_a: assert property ( // (R10)
    EXEC && OP == status_pkg::OP_XOR && !st_hit && W_IN == FILE_IN |=>
      status_r[status_pkg::BIT_Z] && RESULT == 8'h00)
    else $error("zero flag not set");

  borrow_a: assert property ( // (R11)
    EXEC && OP == status_pkg::OP_SUB && !st_hit && W_IN > FILE_IN |=>
      !status_r[status_pkg::BIT_C])
    else $error("borrow not shown");

  rotate_a: assert property ( // (R13)
    EXEC && OP == status_pkg::OP_RLF && !st_hit |=>
      status_r[status_pkg::BIT_C] == $past(FILE_IN[7]))
    else $error("rotate carry wrong");

  nibble_a: assert property ( // (R16)
    EXEC && OP == status_pkg::OP_ADD && !st_hit |=>
      status_r[status_pkg::BIT_DC] ==
      ($past({1'h0, FILE_IN[3:0]}) + $past({1'h0, W_IN[3:0]}) > 5'h0F))
    else $error("digit carry wrong");

  sleep_a: assert property ( // (R15)
    SLEEP_EXEC && !WDT_TIMEOUT |=> status_r[status_pkg::BIT_TO]
      && !status_r[status_pkg::BIT_PD] ##1 1'h1)
    else $error("sleep bits wrong");

  expiry_a: assert property ( // (R15)
    WDT_TIMEOUT |=> !status_r[status_pkg::BIT_TO])
    else $error("timeout bit not cleared");

endmodule
`default_nettype wire

// [sim/core_model.sv]
// Core-side model: instruction execute requests and reset-cause events
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clk,           // Core clock
  output logic exec,              // Execute strobe
  output status_pkg::op_t op,     // Operation
  output logic [6:0] faddr,       // Direct file address
  output logic [2:0] bsel,        // Bit index
  output logic dest,              // Result to file
  output logic [7:0] w,           // Accumulator value
  output logic [7:0] f,           // File operand
  output logic [2:0] ev           // Clear, sleep, expiry pulses
);
  initial begin
    exec = 1'b0;
    op = status_pkg::OP_NOP;
    faddr = 7'h00;
    bsel = 3'h0;
    dest = 1'b0;
    w = 8'h00;
    f = 8'h00;
    ev = 3'h0;
  end

  // ******************************************************************
  // One execute cycle
  // ******************************************************************
  // Operands turn to their inverse once taken, so stale values never
  // look valid to the block
  task automatic run(input status_pkg::op_t o, input logic [7:0] a,
                     input logic [7:0] b, input logic [6:0] ad,
                     input logic d, input logic [2:0] bs);
    @(posedge clk);
    exec <= 1'b1;
    op <= o;
    w <= a;
    f <= b;
    faddr <= ad;
    dest <= d;
    bsel <= bs;
    @(posedge clk);
    exec <= 1'b0;
    op <= status_pkg::OP_NOP;
    w <= ~a;
    f <= ~b;
  endtask

  // ******************************************************************
  // Event pulse
  // ******************************************************************
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 3'h0;
  endtask
endmodule
`default_nettype wire

// [sim/alu_status_register_tb.sv]
// Self-checking bench for the status register block
`timescale 1ns/1ps
`default_nettype none
module alu_status_register_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic exec, dest, r_we, r_w_we;
  status_pkg::op_t op;
  logic [6:0] faddr;
  logic [2:0] bsel, ev;
  logic [7:0] w, f, result, raddr, st, exp_st, q8;
  logic [31:0] q;
  int errors = 0;
  int comparisons = 0;
  int seed = 66;
  status_pkg::op_t rops [0:9];

  always #5 clk = ~clk;
  logic hready_o;
  assign hready = hready_o;

  alu_status_register DUT (.CLK(clk), .NRST(nrst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready_o), .HRESP(hresp), .EXEC(exec), .OP(op),
    .FILE_ADDR(faddr), .BIT_SEL(bsel), .DEST_FILE(dest), .W_IN(w),
    .FILE_IN(f), .WDT_CLEAR(ev[0]), .SLEEP_EXEC(ev[1]),
    .WDT_TIMEOUT(ev[2]), .RESULT(result), .RESULT_ADDR(raddr),
    .RESULT_WE(r_we), .RESULT_W_WE(r_w_we), .STATUS_OUT(st));

  core_model core (.clk(clk), .exec(exec), .op(op), .faddr(faddr),
    .bsel(bsel), .dest(dest), .w(w), .f(f), .ev(ev));

  // ******************************************************************
  // Reporting
  // ******************************************************************
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // ******************************************************************
  // Bus master: single word transfer, waits on hready
  // ******************************************************************
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= status_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    n = 0;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = (n >= 20) ? 40 : 0;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 20);
    q = hrdata;
    hwdata <= ~d;
    chk({31'h0, hresp}, {31'h0, status_pkg::HRESP_OKAY});
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
    #1;
  endtask

  // ******************************************************************
  // Expected result and flags of one operation: {res, z, dc, c}
  // ******************************************************************
  function automatic logic [10:0] alu_exp(input status_pkg::op_t o,
    input logic [7:0] a, input logic [7:0] b, input logic cin,
    input logic [2:0] bs);
    logic [8:0] s;
    logic [4:0] n;
    s = 9'h000;
    n = 5'h00;
    case (o)
      status_pkg::OP_ADD: begin
        s = {1'b0, b} + {1'b0, a};
        n = {1'b0, b[3:0]} + {1'b0, a[3:0]};
      end
      status_pkg::OP_SUB: begin
        s = {1'b0, b} + {1'b0, ~a} + 9'h001;
        n = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
      end
      status_pkg::OP_AND: s = {1'b0, b & a};
      status_pkg::OP_XOR: s = {1'b0, b ^ a};
      status_pkg::OP_IOR: s = {1'b0, b | a};
      status_pkg::OP_INC: s = {1'b0, b + 8'h01};
      status_pkg::OP_DEC: s = {1'b0, b - 8'h01};
      status_pkg::OP_SWAP: s = {1'b0, b[3:0], b[7:4]};
      status_pkg::OP_RLF: s = {b, cin};
      status_pkg::OP_RRF: s = {b[0], cin, b[7:1]};
      status_pkg::OP_BSF: s = {1'b0, b | (8'h01 << bs)};
      default: s = 9'h000;
    endcase
    return {s[7:0], s[7:0] == 8'h00, n[4], s[8]};
  endfunction

  function automatic logic [2:0] aff(input status_pkg::op_t o);
    case (o)
      status_pkg::OP_ADD, status_pkg::OP_SUB: return 3'h7;
      status_pkg::OP_AND, status_pkg::OP_CLR: return 3'h4;
      status_pkg::OP_XOR, status_pkg::OP_IOR: return 3'h4;
      status_pkg::OP_INC, status_pkg::OP_DEC: return 3'h4;
      status_pkg::OP_RLF, status_pkg::OP_RRF: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  // Status target uses the register itself as operand; the flag bits an op affects
  // come from the flag logic and the others hold, and with no flag affected they come from the result data
  task automatic run_op(input status_pkg::op_t o, input logic [7:0] a,
    input logic [7:0] b, input logic [6:0] ad, input logic d,
    input logic [2:0] bs);
    logic hit;
    logic [10:0] e;
    logic [2:0] m, lo;
    hit = (ad == 7'h03);
    e = alu_exp(o, a, hit ? exp_st : b, exp_st[0], bs);
    m = aff(o);
    core.run(o, a, b, ad, d, bs);
    #1;
    chk({24'h0, result}, {24'h0, e[10:3]});
    chk({24'h0, raddr}, {24'h0, exp_st[5], ad});
    chk({30'h0, r_we, r_w_we}, {30'h0, d && !hit, !d});
    lo = (e[2:0] & m) | (exp_st[2:0] & ~m);
    if (hit && d) begin
      if (m == 3'h0) lo = e[5:3];
      exp_st = {e[10:8], exp_st[4:3], lo};
    end else exp_st[2:0] = lo;
    q8 = e[10:3];
    chk({24'h0, st}, {24'h0, exp_st});
  endtask

  task automatic ev_chk(input int k, input logic [7:0] e);
    core.pulse(k);
    #1;
    exp_st = e;
    chk({24'h0, st}, {24'h0, e});
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    rops = '{status_pkg::OP_ADD, status_pkg::OP_SUB, status_pkg::OP_AND,
             status_pkg::OP_RLF, status_pkg::OP_RRF, status_pkg::OP_XOR,
             status_pkg::OP_IOR, status_pkg::OP_INC, status_pkg::OP_DEC,
             status_pkg::OP_SWAP};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    #1;
    exp_st = status_pkg::STATUS_RST;
    chk({24'h0, st}, 32'h18);
    ahb(1'b0, 32'h00C, 32'h0);
    chk(q, 32'h18);
    ahb(1'b0, 32'h20C, 32'h0);
    chk(q, 32'h18);
    ahb(1'b0, 32'h100, 32'h0);
    chk(q, 32'h0);
    ev_chk(1, 8'h10);
    // Software keeps bits 7:6 clear
    ahb(1'b1, 32'h00C, 32'h3F);
    chk({24'h0, st}, 32'h37);
    ahb(1'b0, 32'h20C, 32'h0);
    chk(q, 32'h37);
    ev_chk(2, 8'h27);
    ev_chk(0, 8'h3F);
    run_op(status_pkg::OP_ADD, 8'hE1, 8'h00, 7'h03, 1'b1, 3'h0);
    run_op(status_pkg::OP_CLR, 8'h55, 8'hAA, 7'h03, 1'b1, 3'h0);
    run_op(status_pkg::OP_BSF, 8'h00, 8'h00, 7'h03, 1'b1, 3'h5);
    run_op(status_pkg::OP_ADD, 8'h0F, 8'h01, 7'h10, 1'b1, 3'h0);
    run_op(status_pkg::OP_ADD, 8'h80, 8'h80, 7'h7F, 1'b1, 3'h0);
    run_op(status_pkg::OP_SUB, 8'h01, 8'h10, 7'h11, 1'b0, 3'h0);
    run_op(status_pkg::OP_SUB, 8'h5A, 8'h5A, 7'h12, 1'b1, 3'h0);
    run_op(status_pkg::OP_SUB, 8'h02, 8'h01, 7'h12, 1'b1, 3'h0);
    run_op(status_pkg::OP_RLF, 8'h00, 8'h81, 7'h13, 1'b1, 3'h0);
    run_op(status_pkg::OP_RRF, 8'h00, 8'h01, 7'h13, 1'b1, 3'h0);
    run_op(status_pkg::OP_XOR, 8'h5A, 8'h5A, 7'h14, 1'b1, 3'h0);
    ahb(1'b1, 32'h20C, 32'h00);
    exp_st = exp_st & 8'h18;
    chk({24'h0, st}, {24'h0, exp_st});
    repeat (40) begin
      // Random targets avoid the status location so bits 7:6 stay clear
      run_op(rops[$unsigned($random(seed)) % 10], 8'($random(seed)),
             8'($random(seed)), 7'($random(seed)) | 7'h04,
             1'($random(seed)), 3'h0);
    end
    ahb(1'b0, 32'h040, 32'h0);
    chk(q, {24'h0, q8});
    end_of_test();
  end
endmodule
`default_nettype wire
